// *** design/sfw_pkg.sv ***
// Constants, opcodes, register map and timing for the serial flash write host
package sfw_pkg;

	// ==========================================================
	// Device opcodes
	localparam logic [7:0] OP_LD1_B1 = 8'h84;
	localparam logic [7:0] OP_LD1_B2 = 8'h87;
	localparam logic [7:0] OP_LD2_B1 = 8'h24;
	localparam logic [7:0] OP_LD2_B2 = 8'h27;
	localparam logic [7:0] OP_LD4_B1 = 8'h44;
	localparam logic [7:0] OP_LD4_B2 = 8'h47;
	localparam logic [7:0] OP_PE_B1 = 8'h83;
	localparam logic [7:0] OP_PE_B2 = 8'h86;
	localparam logic [7:0] OP_PN_B1 = 8'h88;
	localparam logic [7:0] OP_PN_B2 = 8'h89;
	localparam logic [7:0] OP_LPE_B1 = 8'h82;
	localparam logic [7:0] OP_LPE_B2 = 8'h85;

	// ==========================================================
	// Command kinds and lane codes
	localparam logic [1:0] KIND_LOAD = 2'h0;
	localparam logic [1:0] KIND_PROG_ERASE = 2'h1;
	localparam logic [1:0] KIND_PROG_ONLY = 2'h2;
	localparam logic [1:0] KIND_LOAD_PROG = 2'h3;
	localparam logic [1:0] LANE_1 = 2'h0;
	localparam logic [1:0] LANE_2 = 2'h1;
	localparam logic [1:0] LANE_4 = 2'h2;

	// ==========================================================
	// Register offsets and fields
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0C;
	localparam int CTRL_KIND_LSB = 0;
	localparam int CTRL_BUF2_BIT = 2;
	localparam int CTRL_LANE_LSB = 3;
	localparam int CTRL_P512_BIT = 5;
	localparam int CTRL_QE_BIT = 6;
	localparam int CTRL_START_BIT = 7;
	localparam int ADDR_PAGE_LSB = 0;
	localparam int ADDR_IDX_LSB = 16;
	localparam int DATA_LAST_BIT = 8;
	localparam int STAT_REFUSED_BIT = 2;
	localparam int DSTAT_READY_BIT = 7;
	localparam int DSTAT_EPE_BIT = 5;
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [12:0] PAGE_RST = 13'h0000;
	localparam logic [9:0] IDX_RST = 10'h000;
	localparam logic [7:0] DSTAT_RST = 8'h00;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCK_PERIOD_NS = 400;
	localparam int SCK_DIV = SCK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [2:0] DIV_LAST = 3'(SCK_DIV - 1);
	localparam logic [2:0] DIV_RISE = 3'(SCK_DIV / 2 - 1);
	localparam int CS_HIGH_NS = 400;
	localparam logic [4:0] CS_HIGH_CYC = 5'((CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPC,
		ST_ADR,
		ST_DAT,
		ST_HOLD,
		ST_GAP,
		ST_SOP,
		ST_SRD
	} sfw_state_e;

endpackage : sfw_pkg

// *** design/sfw_host.sv ***
// Host controller that loads flash buffers and commits them to pages over SPI
// Behaviour
// - Single-bit buffer load uses 84h (buffer one) or 87h (buffer two).
// - 528-byte layout: fourteen don't-care bits then ten-bit buffer byte index.
// - 512-byte layout: fifteen don't-care bits then nine-bit buffer byte index.
// - Dual load uses 24h or 27h, two bits per clock.
// - Quad load uses 44h or 47h, four bits per clock.
// - Program with erase uses 83h or 86h.
// - 528-byte page commands: one don't-care, 13-bit page, ten trailing bits.
// - 512-byte page commands: two don't-care, 13-bit page, nine trailing bits.
// - Program without erase uses 88h or 89h, written on select rise.
// - Page must be erased before program without erase; the host sends 88h or 89h without erasing or checking it.
// - Load-then-erase-then-program uses 82h or 85h.
// - Combined command trailing bits carry buffer start index, ten or nine.
// - Quad commands only when quad enable set; frees reset and protect pins.
module sfw_host #(
	parameter logic [7:0] STATUS_OP = 8'hD7
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic sck,
	output logic cs_n,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe
);

	// ==========================================================
	// Helpers
	// Opcode for a command kind, buffer and lane count
	function automatic logic [7:0] op_sel(input logic [1:0] kind, input logic b2,
		input logic [1:0] lanes);
		logic [7:0] op;
		op = b2 ? sfw_pkg::OP_LD1_B2 : sfw_pkg::OP_LD1_B1;
		case (kind)
			sfw_pkg::KIND_LOAD:
			begin
				if (lanes == sfw_pkg::LANE_2)
					op = b2 ? sfw_pkg::OP_LD2_B2 : sfw_pkg::OP_LD2_B1;
				else if (lanes == sfw_pkg::LANE_4)
					op = b2 ? sfw_pkg::OP_LD4_B2 : sfw_pkg::OP_LD4_B1;
			end
			sfw_pkg::KIND_PROG_ERASE: op = b2 ? sfw_pkg::OP_PE_B2 : sfw_pkg::OP_PE_B1;
			sfw_pkg::KIND_PROG_ONLY: op = b2 ? sfw_pkg::OP_PN_B2 : sfw_pkg::OP_PN_B1;
			default: op = b2 ? sfw_pkg::OP_LPE_B2 : sfw_pkg::OP_LPE_B1;
		endcase
		return op;
	endfunction : op_sel

	// Three address bytes for a command kind and page layout
	function automatic logic [23:0] addr_build(input logic [1:0] kind, input logic p512,
		input logic [12:0] page, input logic [9:0] idx);
		logic [23:0] a;
		a = 24'h000000;
		case (kind)
			sfw_pkg::KIND_LOAD: a = p512 ? {15'h0000, idx[8:0]} : {14'h0000, idx};
			sfw_pkg::KIND_LOAD_PROG:
				a = p512 ? {2'h0, page, idx[8:0]} : {1'h0, page, idx};
			default: a = p512 ? {2'h0, page, 9'h000} : {1'h0, page, 10'h000};
		endcase
		return a;
	endfunction : addr_build

	// Bits moved per clock for a lane code
	function automatic logic [3:0] lane_step(input logic [1:0] lanes);
		case (lanes)
			sfw_pkg::LANE_2: return 4'h2;
			sfw_pkg::LANE_4: return 4'h4;
			default: return 4'h1;
		endcase
	endfunction : lane_step

	// ==========================================================
	// Storage
	sfw_pkg::sfw_state_e state_q;
	logic [6:0] ctrl_q;
	logic [12:0] page_q;
	logic [9:0] idx_q;
	logic [7:0] hold_q;
	logic hold_last_q, hold_full_q, start_q, refused_q;
	logic [7:0] sh_q, dstat_q;
	logic [3:0] cnt_q;
	logic [1:0] wid_q, abyte_q, kind_q;
	logic [23:0] addr_q;
	logic last_q, poll_q;
	logic [2:0] div_q;
	logic [4:0] gap_q;
	logic [3:0] io_m_q, io_s_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, sck_q, cs_n_q;
	logic [3:0] io_o_q, io_oe_q;

	logic [1:0] c_kind, c_lanes;
	logic c_b2, c_p512, c_qe;
	assign c_kind = ctrl_q[sfw_pkg::CTRL_KIND_LSB +: 2];
	assign c_b2 = ctrl_q[sfw_pkg::CTRL_BUF2_BIT];
	assign c_lanes = ctrl_q[sfw_pkg::CTRL_LANE_LSB +: 2];
	assign c_p512 = ctrl_q[sfw_pkg::CTRL_P512_BIT];
	assign c_qe = ctrl_q[sfw_pkg::CTRL_QE_BIT];

	// ==========================================================
	// APB slave
	logic access, wr, mapped, data_stall;
	logic [31:0] rd_w;
	assign access = psel && penable && pready_q;
	assign wr = access && pwrite;
	assign mapped = (paddr == sfw_pkg::OFF_CTRL) || (paddr == sfw_pkg::OFF_ADDR) ||
		(paddr == sfw_pkg::OFF_DATA) || (paddr == sfw_pkg::OFF_STAT);
	assign data_stall = pwrite && (paddr == sfw_pkg::OFF_DATA) && hold_full_q;

	// Read data mux
	always_comb
	begin
		rd_w = 32'h00000000;
		case (paddr)
			sfw_pkg::OFF_CTRL: rd_w = {25'h0000000, ctrl_q};
			sfw_pkg::OFF_ADDR: rd_w = {6'h00, idx_q, 3'h0, page_q};
			sfw_pkg::OFF_STAT: rd_w = {15'h0000, dstat_q[sfw_pkg::DSTAT_EPE_BIT], dstat_q,
				4'h0, poll_q, refused_q, hold_full_q, state_q != sfw_pkg::ST_IDLE};
			default: rd_w = 32'h00000000;
		endcase
	end

	// Answer one cycle into access; stall data writes while holding is full
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0; // Error stands only with ready
			if (psel && penable && !pready_q && !data_stall)
			begin
				pready_q <= 1'b1;
				pslverr_q <= !mapped;
				prdata_q <= pwrite ? 32'h00000000 : rd_w;
			end
		end
	end

	// Configuration and address registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= sfw_pkg::CTRL_RST;
			page_q <= sfw_pkg::PAGE_RST;
			idx_q <= sfw_pkg::IDX_RST;
			start_q <= 1'b0;
		end
		else
		begin
			start_q <= wr && (paddr == sfw_pkg::OFF_CTRL) && pwdata[sfw_pkg::CTRL_START_BIT];
			if (wr && paddr == sfw_pkg::OFF_CTRL)
				ctrl_q <= pwdata[6:0];
			if (wr && paddr == sfw_pkg::OFF_ADDR)
			begin
				page_q <= pwdata[sfw_pkg::ADDR_PAGE_LSB +: 13];
				idx_q <= pwdata[sfw_pkg::ADDR_IDX_LSB +: 10];
			end
		end
	end

	// ==========================================================
	// Sequencer
	logic shifting, tick_end, byte_done, take, launch_ok, refuse;
	assign shifting = (state_q == sfw_pkg::ST_OPC) || (state_q == sfw_pkg::ST_ADR) ||
		(state_q == sfw_pkg::ST_DAT) || (state_q == sfw_pkg::ST_SOP) ||
		(state_q == sfw_pkg::ST_SRD);
	assign tick_end = shifting && (div_q == sfw_pkg::DIV_LAST);
	assign byte_done = tick_end && (cnt_q == lane_step(wid_q));
	assign take = hold_full_q && ((state_q == sfw_pkg::ST_HOLD) ||
		(byte_done && state_q == sfw_pkg::ST_ADR && abyte_q == 2'h0 &&
		(kind_q == sfw_pkg::KIND_LOAD || kind_q == sfw_pkg::KIND_LOAD_PROG)) ||
		(byte_done && state_q == sfw_pkg::ST_DAT && !last_q));
	assign launch_ok = (c_kind != sfw_pkg::KIND_LOAD) || (c_lanes == sfw_pkg::LANE_1) ||
		(c_lanes == sfw_pkg::LANE_2) || (c_lanes == sfw_pkg::LANE_4 && c_qe);
	assign refuse = start_q && ((state_q != sfw_pkg::ST_IDLE) || !launch_ok);

	// Status byte as it stands with the final sample
	logic [7:0] srd_byte;
	assign srd_byte = {sh_q[6:0], io_s_q[1]};

	// Holding byte fed by software; the set by a write wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hold_q <= 8'h00;
			hold_last_q <= 1'b0;
			hold_full_q <= 1'b0;
			refused_q <= 1'b0;
		end
		else
		begin
			if (wr && paddr == sfw_pkg::OFF_DATA)
			begin
				hold_q <= pwdata[7:0];
				hold_last_q <= pwdata[sfw_pkg::DATA_LAST_BIT];
				hold_full_q <= 1'b1;
			end
			else if (take)
				hold_full_q <= 1'b0;
			if (refuse)
				refused_q <= 1'b1;
			else if (wr && paddr == sfw_pkg::OFF_STAT && pwdata[sfw_pkg::STAT_REFUSED_BIT])
				refused_q <= 1'b0;
		end
	end

	// SCK phase divider
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_q <= 3'h0;
		else if (!shifting || tick_end)
			div_q <= 3'h0;
		else
			div_q <= div_q + 3'h1;
	end

	// Frame sequencing and shifting
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= sfw_pkg::ST_IDLE;
			sh_q <= 8'h00;
			cnt_q <= 4'h0;
			wid_q <= sfw_pkg::LANE_1;
			abyte_q <= 2'h0;
			kind_q <= sfw_pkg::KIND_LOAD;
			addr_q <= 24'h000000;
			last_q <= 1'b0;
			poll_q <= 1'b0;
			gap_q <= 5'h00;
			dstat_q <= sfw_pkg::DSTAT_RST;
		end
		else
		begin
			if (tick_end && !byte_done)
			begin
				cnt_q <= cnt_q - lane_step(wid_q);
				if (state_q == sfw_pkg::ST_SRD)
					sh_q <= {sh_q[6:0], io_s_q[1]};
				else
					sh_q <= sh_q << lane_step(wid_q);
			end
			case (state_q)
				sfw_pkg::ST_IDLE:
				begin
					if (start_q && launch_ok)
					begin
						state_q <= sfw_pkg::ST_OPC;
						sh_q <= op_sel(c_kind, c_b2, c_lanes);
						cnt_q <= 4'h8;
						wid_q <= sfw_pkg::LANE_1;
						kind_q <= c_kind;
						addr_q <= addr_build(c_kind, c_p512, page_q, idx_q);
						abyte_q <= 2'h2;
					end
				end
				sfw_pkg::ST_OPC:
				begin
					if (byte_done)
					begin
						state_q <= sfw_pkg::ST_ADR;
						sh_q <= addr_q[23:16];
						cnt_q <= 4'h8;
					end
				end
				sfw_pkg::ST_ADR:
				begin
					if (byte_done)
					begin
						cnt_q <= 4'h8;
						abyte_q <= abyte_q - 2'h1;
						if (abyte_q == 2'h2)
							sh_q <= addr_q[15:8];
						else if (abyte_q == 2'h1)
							sh_q <= addr_q[7:0];
						else if (kind_q == sfw_pkg::KIND_LOAD ||
							kind_q == sfw_pkg::KIND_LOAD_PROG)
						begin
							wid_q <= (kind_q == sfw_pkg::KIND_LOAD) ? c_lanes : sfw_pkg::LANE_1;
							state_q <= take ? sfw_pkg::ST_DAT : sfw_pkg::ST_HOLD;
							sh_q <= hold_q;
							last_q <= hold_last_q;
						end
						else
						begin
							state_q <= sfw_pkg::ST_GAP;
							poll_q <= 1'b1;
							gap_q <= 5'h00;
						end
					end
				end
				sfw_pkg::ST_HOLD:
				begin
					if (take)
					begin
						state_q <= sfw_pkg::ST_DAT;
						sh_q <= hold_q;
						last_q <= hold_last_q;
						cnt_q <= 4'h8;
					end
				end
				sfw_pkg::ST_DAT:
				begin
					if (byte_done)
					begin
						cnt_q <= 4'h8;
						if (last_q)
						begin
							state_q <= sfw_pkg::ST_GAP;
							poll_q <= (kind_q == sfw_pkg::KIND_LOAD_PROG);
							gap_q <= 5'h00;
						end
						else
						begin
							state_q <= take ? sfw_pkg::ST_DAT : sfw_pkg::ST_HOLD;
							sh_q <= hold_q;
							last_q <= hold_last_q;
						end
					end
				end
				sfw_pkg::ST_GAP:
				begin
					gap_q <= gap_q + 5'h01;
					if (gap_q == sfw_pkg::CS_HIGH_CYC - 5'h01)
					begin
						if (poll_q)
						begin
							state_q <= sfw_pkg::ST_SOP;
							sh_q <= STATUS_OP;
							cnt_q <= 4'h8;
							wid_q <= sfw_pkg::LANE_1;
						end
						else
							state_q <= sfw_pkg::ST_IDLE;
					end
				end
				sfw_pkg::ST_SOP:
				begin
					if (byte_done)
					begin
						state_q <= sfw_pkg::ST_SRD;
						cnt_q <= 4'h8;
					end
				end
				sfw_pkg::ST_SRD:
				begin
					if (byte_done)
					begin
						cnt_q <= 4'h8;
						dstat_q <= srd_byte;
						if (srd_byte[sfw_pkg::DSTAT_READY_BIT])
						begin
							state_q <= sfw_pkg::ST_GAP;
							poll_q <= 1'b0;
							gap_q <= 5'h00;
						end
					end
				end
				default: state_q <= sfw_pkg::ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Pins
	// Input synchroniser
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			io_m_q <= 4'h0;
			io_s_q <= 4'h0;
		end
		else
		begin
			io_m_q <= io_i;
			io_s_q <= io_m_q;
		end
	end

	// Clock, select and data lanes; idle lines two and three held high while quad enable is clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sck_q <= 1'b0;
			cs_n_q <= 1'b1;
			io_o_q <= 4'hC;
			io_oe_q <= 4'hD;
		end
		else
		begin
			sck_q <= shifting && (div_q >= sfw_pkg::DIV_RISE) && (div_q < sfw_pkg::DIV_LAST);
			cs_n_q <= (state_q == sfw_pkg::ST_IDLE) || (state_q == sfw_pkg::ST_GAP);
			io_o_q <= {2'h3, 1'b0, sh_q[7]};
			io_oe_q <= c_qe ? 4'h1 : 4'hD;
			if (state_q == sfw_pkg::ST_DAT && wid_q == sfw_pkg::LANE_4)
			begin
				io_o_q <= sh_q[7:4];
				io_oe_q <= 4'hF;
			end
			else if (state_q == sfw_pkg::ST_DAT && wid_q == sfw_pkg::LANE_2)
			begin
				io_o_q <= {2'h3, sh_q[7:6]};
				io_oe_q <= c_qe ? 4'h3 : 4'hF;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign sck = sck_q;
	assign cs_n = cs_n_q;
	assign io_o = io_o_q;
	assign io_oe = io_oe_q;

endmodule : sfw_host

// *** verification/sfw_host_assertions.sv ***
// Checker on the host ports: bus answers and link timing
module sfw_host_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] io_o,
	input wire logic [3:0] io_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ==========================================
	// Link sequences
	sequence s_sck_high;
		sck [*4] ##1 !sck;
	endsequence
	sequence s_cs_gap;
		cs_n [*8];
	endsequence
	// ==========================================
	// Bus answer
	property p_rdy;
		psel && penable && !pready && !$past(penable) && !(pwrite && paddr == 8'h08) |=> pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("bus access not answered in time");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready held too long");
	property p_err_rdy;
		pslverr |-> pready;
	endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
	property p_unmap;
		pready && paddr > 8'h0C |-> pslverr;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access not flagged");
	// ==========================================
	// Link timing
	property p_sck_idle;
		cs_n |-> !sck;
	endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("link clock moves outside frame");
	property p_sck_hi;
		$rose(sck) |-> s_sck_high;
	endproperty
	a_sck_hi: assert property (p_sck_hi) else $error("link clock high phase wrong");
	property p_sck_gap;
		$rose(sck) |=> (!$rose(sck)) [*7];
	endproperty
	a_sck_gap: assert property (p_sck_gap) else $error("link clock period too short");
	property p_stable;
		sck |-> $stable(io_o);
	endproperty
	a_stable: assert property (p_stable) else $error("data moved while clock high");
	property p_cs_gap;
		$rose(cs_n) |-> s_cs_gap;
	endproperty
	a_cs_gap: assert property (p_cs_gap) else $error("select high time too short");
	property p_so_free;
		$rose(cs_n) |-> ##2 (!io_oe[1]) [*6];
	endproperty
	a_so_free: assert property (p_so_free) else $error("output line driven after frame");
endmodule : sfw_host_assertions

bind sfw_host sfw_host_assertions sfw_host_assertions_inst (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pready, .pslverr, .sck, .cs_n, .io_o, .io_oe);

// *** verification/sfw_flash_model.sv ***
// Flash device model: command decode, buffer capture, status answers
module sfw_flash_model #(
	parameter logic [7:0] STATUS_OP = 8'hD7
) (
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] io,
	input wire logic epe_inj,
	output logic so
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] op = 8'h00;
	logic [23:0] adr = 24'h000000;
	logic [7:0] sh = 8'h00;
	logic [7:0] stb = 8'h00;
	logic [7:0] bytes [$];
	logic pol = 1'b0;
	int cnt = 0;
	int w = 1;
	int ob = 7;
	int busy = 0;
	initial so = 1'b0;
	// ==========================================
	// Frame start
	always @(negedge cs_n)
	begin
		cnt = 0;
		ob = 7;
	end
	// Bits in on rising link clock, top lane first
	always @(posedge sck)
	begin
		if (!cs_n)
		begin
			w = (cnt < 32) ? 1 : (op[7:4] == 4'h2) ? 2 : (op[7:4] == 4'h4) ? 4 : 1;
			for (int i = w - 1; i >= 0; i--)
				sh = {sh[6:0], io[i]};
			cnt = cnt + w;
			if (cnt == 8)
			begin
				pol = (sh == STATUS_OP);
				if (!pol)
					op = sh;
			end
			else if (cnt % 8 == 0 && !pol)
			begin
				if (cnt <= 32)
					adr = {adr[15:0], sh};
				else
					bytes.push_back(sh);
			end
		end
	end
	// Status bytes out on falling link clock
	always @(negedge sck)
	begin
		if (pol && !cs_n)
		begin
			if (ob == 7)
				stb = {busy == 0, 1'b0, epe_inj, 5'h00};
			so <= stb[ob];
			if (ob == 0 && busy > 0)
				busy = busy - 1;
			ob = (ob == 0) ? 7 : ob - 1;
		end
	end
	// Frame end: invert the output line, launch programming
	always @(posedge cs_n)
	begin
		so <= ~so;
		if (!pol && cnt >= 32 && op inside {8'h82, 8'h83, 8'h85, 8'h86, 8'h88, 8'h89})
			busy = 2;
		pol = 1'b0;
	end
endmodule : sfw_flash_model

// *** verification/sfw_host_tb_top.sv ***
// Self-checking bench for the serial flash write host
module sfw_host_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, sck, cs_n, so, erx;
	logic [3:0] io_o, io_oe, pin;
	logic epe_inj = 1'b0;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	// ==========================================
	// Clock, pins and instances
	always #25 pclk = ~pclk;
	assign pin = (io_oe & io_o) | (~io_oe & {2'b11, so, 1'b1});
	sfw_host sfw_host_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .sck, .cs_n, .io_i(pin), .io_o, .io_oe);
	sfw_flash_model sfw_flash_model_inst (.sck, .cs_n, .io(pin), .epe_inj, .so);
	// ==========================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		erx = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic run(input logic [6:0] ctl, input logic [25:0] adr, input int nb);
		sfw_flash_model_inst.bytes.delete();
		apb(1'b1, 8'h04, 32'(adr));
		if (nb > 0)
			apb(1'b1, 8'h08, {23'h0, nb == 1, 8'hA5});
		apb(1'b1, 8'h00, {24'h0, 1'b1, ctl});
		for (int i = 1; i < nb; i++)
			apb(1'b1, 8'h08, {23'h0, i == nb - 1, 8'hA5 + 8'(i)});
		repeat (4) @(posedge pclk);
		do
			apb(1'b0, 8'h0C, 32'h0);
		while (rd[0] !== 1'b0);
		check(32'(sfw_flash_model_inst.bytes.size()), 32'(nb));
		for (int i = 0; i < nb; i++)
			check(32'(sfw_flash_model_inst.bytes[i]), 32'(8'hA5 + 8'(i)));
	endtask : run
	// ==========================================
	// Scenarios
	task automatic t_reset();
		check(32'({sck, cs_n, io_o, io_oe}), 32'h1CD);
		apb(1'b0, 8'h00, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		check({rd[30:0], erx}, 32'h1);
	endtask : t_reset
	task automatic t_load();
		logic [7:0] lop [6] = '{8'h84, 8'h87, 8'h24, 8'h27, 8'h44, 8'h47};
		logic [9:0] idx;
		for (int n = 0; n < 6; n++)
		begin
			idx = n[0] ? 10'h1FF : 10'h3FE;
			run({n > 3, n[0], 2'(n / 2), n[0], 2'h0}, {idx, 16'h0}, 2);
			check(32'(sfw_flash_model_inst.op), 32'(lop[n]));
			check(32'(sfw_flash_model_inst.adr & (n[0] ? 24'h1FF : 24'h3FF)), 32'(idx));
		end
	endtask : t_load
	task automatic t_prog();
		logic [7:0] pop [4] = '{8'h83, 8'h86, 8'h88, 8'h89};
		for (int n = 0; n < 4; n++)
		begin
			epe_inj <= n[1];
			run({1'b0, n[0], 2'h0, n[0], 2'(1 + n / 2)}, 26'h1A5B, 0);
			check(32'(sfw_flash_model_inst.op), 32'(pop[n]));
			check(32'((sfw_flash_model_inst.adr >> (n[0] ? 9 : 10)) & 24'h1FFF), 32'h1A5B);
			check(32'(rd[16:15]), {30'h0, n[1], 1'b1});
		end
		epe_inj <= 1'b0;
	endtask : t_prog
	task automatic t_comb();
		for (int n = 0; n < 2; n++)
		begin
			run({1'b0, n[0], 2'h0, n[0], 2'h3}, {10'h005, 3'h0, 13'h0C3D}, 3);
			check(32'(sfw_flash_model_inst.op), n[0] ? 32'h85 : 32'h82);
			check(32'(sfw_flash_model_inst.adr & (n[0] ? 24'h3FFFFF : 24'h7FFFFF)),
				n[0] ? {10'h0, 13'h0C3D, 9'h005} : {9'h0, 13'h0C3D, 10'h005});
		end
	endtask : t_comb
	task automatic t_refuse();
		sfw_flash_model_inst.op = 8'h00;
		apb(1'b1, 8'h00, 32'h90);
		apb(1'b0, 8'h0C, 32'h0);
		check(32'(rd[2]), 32'h1);
		apb(1'b1, 8'h0C, 32'h4);
		apb(1'b0, 8'h0C, 32'h0);
		check(32'({rd[2], sfw_flash_model_inst.op}), 32'h0);
		apb(1'b1, 8'h00, 32'h98);
		apb(1'b0, 8'h00, 32'h0);
		check(rd, 32'h18);
		apb(1'b0, 8'h0C, 32'h0);
		check(32'({rd[2], sfw_flash_model_inst.op}), 32'h100);
		apb(1'b1, 8'h0C, 32'h4);
	endtask : t_refuse
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	// ==========================================
	// Hang guard
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_total++;
			conclude();
		end
	end
	// Main sequence
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_load();
		t_prog();
		t_comb();
		t_refuse();
		conclude();
	end
endmodule : sfw_host_tb_top
